// ===== hw/cmpio_defines.vh
// constants for the comparator control block: register offsets, field positions, reset values
// assumes inclusion by plain name from the design files under hw/
`ifndef CMPIO_DEFINES_VH
`define CMPIO_DEFINES_VH

`define CMPIO_OFF_CTRL      12'h000
`define CMPIO_OFF_SEL       12'h004
`define CMPIO_OFF_STAT      12'h008
`define CMPIO_OFF_MASK      12'h00c
`define CMPIO_OFF_ANA       12'h010

`define CMPIO_CTRL_EN       7
`define CMPIO_CTRL_RES      6
`define CMPIO_CTRL_SAMP     5
`define CMPIO_CTRL_INV      4
`define CMPIO_CTRL_NSEL_HI  3
`define CMPIO_CTRL_NSEL_LO  1
`define CMPIO_CTRL_PSEL     0
`define CMPIO_CTRL_WMASK    8'hbf

`define CMPIO_SEL_PINOUT    7
`define CMPIO_SEL_CFG_HI    5
`define CMPIO_SEL_CFG_LO    4
`define CMPIO_SEL_TAP_HI    3
`define CMPIO_SEL_TAP_LO    0
`define CMPIO_SEL_WMASK     8'hbf

`define CMPIO_CTRL_RST      8'h00
`define CMPIO_SEL_RST       8'h00

`define CMPIO_NSEL_PIN_THREE 3'h0
`define CMPIO_NSEL_PIN_FOUR  3'h1
`define CMPIO_NSEL_BGAP      3'h2
`define CMPIO_NSEL_PIN_SIX   3'h3
`define CMPIO_NSEL_PIN_SEVEN 3'h4
`define CMPIO_NSEL_LADDER    3'h5
`define CMPIO_NSEL_NONE      3'h7

`define CMPIO_PSEL_PIN_FOUR 1'b0
`define CMPIO_PSEL_LADDER   1'b1

`define CMPIO_INT_RISE      0
`define CMPIO_INT_FALL      1

`endif

// ===== hw/cmpio_result.v
// result path of the comparator: direct or sampled, polarity, enable gating
// assumes cmp_raw is already synchronised to clk_sys and tick is a one-cycle enable
module cmpio_result (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire enable,
  input  wire sampled,
  input  wire invert,
  input  wire tick,
  input  wire cmp_raw,
  output wire result
);
  reg hold_r;

  // the held sample survives mode changes so a switch to sampled mode starts from the last tick
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hold_r <= 1'b0;
    end else if (tick) begin
      hold_r <= cmp_raw;
    end
  end

  wire pre = sampled ? hold_r : cmp_raw;
  assign result = enable & (pre ^ invert);
endmodule

// ===== hw/cmpio_top.v
// comparator input/output control: source selects, ladder selects, result routing, apb registers
// assumes an analog comparator outside that takes the selects and returns cmp_out asynchronously,
// and a timer that gives a one-cycle timer2_prescaled_clock enable in the clk_sys domain
// Function
// - minus input chosen from six sources
// - plus input is pin four or ladder
// - select bit seven forces result onto pin zero while control bit seven is set
// - control bit five picks direct or sampled
// - control bit four inverts every result use
// - result readable at bit six, raises interrupt
// - select bits five:four choose ladder span
// - select bits three:zero pick one of sixteen
// - span zero gives supply times (n+9)/32
// - span two gives supply times (n+9)/40
// - bandgap minus with ladder plus allowed
`include "cmpio_defines.vh"

module cmpio_top #(
  parameter AW = 12
) (
  input  wire          clk_sys,
  input  wire          rst_b,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          timer2_prescaled_clock,
  input  wire          cmp_out,
  output reg  [2:0]    minus_sel,
  output reg           plus_sel,
  output reg  [1:0]    ladder_cfg,
  output reg  [3:0]    ladder_tap,
  output reg           cmp_enable,
  output reg           port_a_pin_zero_o,
  output reg           port_a_pin_zero_oe,
  output reg           irq
);
  reg  [7:0] ctrl_r;
  reg  [7:0] sel_r;
  reg  [1:0] stat_r;
  reg  [1:0] mask_r;
  reg        cmp_s1_r;
  reg        cmp_s2_r;
  reg        res_d_r;
  wire       result;

  // analog output is asynchronous to clk_sys
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_out;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  cmpio_result u_res (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .enable  (ctrl_r[`CMPIO_CTRL_EN]),
    .sampled (ctrl_r[`CMPIO_CTRL_SAMP]),
    .invert  (ctrl_r[`CMPIO_CTRL_INV]),
    .tick    (timer2_prescaled_clock),
    .cmp_raw (cmp_s2_r),
    .result  (result)
  );

  wire setup_ph = psel & ~penable;
  wire acc_ph   = psel & penable;
  wire hit_ctrl = (paddr == `CMPIO_OFF_CTRL);
  wire hit_sel  = (paddr == `CMPIO_OFF_SEL);
  wire hit_stat = (paddr == `CMPIO_OFF_STAT);
  wire hit_mask = (paddr == `CMPIO_OFF_MASK);
  wire hit_ana  = (paddr == `CMPIO_OFF_ANA);
  wire hit_any  = hit_ctrl | hit_sel | hit_stat | hit_mask | hit_ana;
  wire wr_fire  = acc_ph & pready & pwrite;

  // edges of the final result, after enable and polarity, feed the status bits
  wire ev_rise = result & ~res_d_r;
  wire ev_fall = ~result & res_d_r;
  wire [1:0] ev = {ev_fall, ev_rise};
  wire [1:0] w1c = (wr_fire & hit_stat) ? pwdata[1:0] : 2'h0;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r  <= `CMPIO_CTRL_RST;
      sel_r   <= `CMPIO_SEL_RST;
      mask_r  <= 2'h0;
      stat_r  <= 2'h0;
      res_d_r <= 1'b0;
    end else begin
      res_d_r <= result;
      // a new edge beats a simultaneous write-one-to-clear
      stat_r  <= (stat_r & ~w1c) | ev;
      if (wr_fire & hit_ctrl) begin
        ctrl_r <= pwdata[7:0] & `CMPIO_CTRL_WMASK;
      end
      if (wr_fire & hit_sel) begin
        sel_r <= pwdata[7:0] & `CMPIO_SEL_WMASK;
      end
      if (wr_fire & hit_mask) begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  // no wait state: ready is raised in the first access cycle and answered at its edge
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_any;
      if (setup_ph) begin
        prdata <= 32'h0000_0000;
        if (hit_ctrl) begin
          prdata[7:0] <= {ctrl_r[7], result, ctrl_r[5:0]};
        end
        if (hit_sel) begin
          prdata[7:0] <= sel_r;
        end
        if (hit_stat) begin
          prdata[1:0] <= stat_r;
        end
        if (hit_mask) begin
          prdata[1:0] <= mask_r;
        end
        if (hit_ana) begin
          prdata[0] <= cmp_s2_r;
        end
      end else begin
        // read data stands only in the cycle in which pready is high
        prdata <= 32'h0000_0000;
      end
    end
  end

  // analog selects: the ladder itself turns cfg/tap into the fractions, this block only steers
  // ratios: cfg 00 -> (n+9)/32, cfg 10 -> (n+9)/40; the bandgap/ladder pair is a legal setting
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      minus_sel          <= `CMPIO_NSEL_NONE;
      plus_sel           <= `CMPIO_PSEL_PIN_FOUR;
      ladder_cfg         <= 2'h0;
      ladder_tap         <= 4'h0;
      cmp_enable         <= 1'b0;
      port_a_pin_zero_o  <= 1'b0;
      port_a_pin_zero_oe <= 1'b0;
      irq                <= 1'b0;
    end else begin
      // codes 6 and 7 have no source and leave the minus input open
      minus_sel  <= ctrl_r[`CMPIO_CTRL_NSEL_HI:`CMPIO_CTRL_NSEL_LO];
      plus_sel   <= ctrl_r[`CMPIO_CTRL_PSEL];
      ladder_cfg <= sel_r[`CMPIO_SEL_CFG_HI:`CMPIO_SEL_CFG_LO];
      ladder_tap <= sel_r[`CMPIO_SEL_TAP_HI:`CMPIO_SEL_TAP_LO];
      cmp_enable <= ctrl_r[`CMPIO_CTRL_EN];
      // the forced output overrides whatever direction the port logic holds for pin zero
      port_a_pin_zero_oe <= sel_r[`CMPIO_SEL_PINOUT] & ctrl_r[`CMPIO_CTRL_EN];
      port_a_pin_zero_o  <= sel_r[`CMPIO_SEL_PINOUT] & result;
      irq <= |(((stat_r & ~w1c) | ev) & mask_r);
    end
  end
endmodule

// ===== tb/cmpio_analog_model.sv
// behavioural comparator, reference ladder and pins (all pins share one level)
// assumes levels in millivolts; the simulator sees no real analog settling
module cmpio_analog_model (
  input wire [2:0]  minus_sel,
  input wire        plus_sel,
  input wire [1:0]  ladder_cfg,
  input wire [3:0]  ladder_tap,
  input wire [31:0] vdd_mv,
  input wire [31:0] pin_mv,
  output wire       cmp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [31:0] n = {28'h0, ladder_tap};
  wire [31:0] lad = ladder_cfg == 2'h0 ? vdd_mv * (n + 9) / 32 :
                    ladder_cfg == 2'h2 ? vdd_mv * (n + 9) / 40 :
                    ladder_cfg == 2'h1 ? vdd_mv * (n + 1) / 24 : vdd_mv * (n + 1) / 32;
  wire [31:0] mn = minus_sel == 3'h2 ? 32'd1200 : minus_sel == 3'h5 ? lad : pin_mv;
  wire [31:0] pl = plus_sel ? lad : pin_mv;
  assign cmp_out = pl > mn;
endmodule

// ===== tb/cmpio_top_properties.sv
// port checker for cmpio_top
// assumes the register offsets of the block and zero wait states per transfer
module cmpio_props #(parameter AW = 12) (
  input wire          clk_sys,
  input wire          rst_b,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0]   pwdata,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  input wire          plus_sel,
  input wire [1:0]    ladder_cfg,
  input wire [3:0]    ladder_tap,
  input wire          cmp_enable,
  input wire          port_a_pin_zero_o,
  input wire          port_a_pin_zero_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire wr = psel & penable & pready & pwrite;
  reg [7:0] ctl_r, sel_r;
  reg wr_d_r;
  // shadow copies let outputs lag the write edge by one cycle
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 8'h00;
      sel_r <= 8'h00;
      wr_d_r <= 1'b0;
    end else begin
      wr_d_r <= wr;
      if (wr && paddr == 'h0) ctl_r <= pwdata[7:0];
      if (wr && paddr == 'h4) sel_r <= pwdata[7:0];
    end
  end
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside answer");
  property p_gap; psel && penable && pready && paddr > 'h10 |-> pslverr; endproperty
  a_gap: assert property (p_gap) else $error("unmapped access accepted");
  property p_sel; !wr && !wr_d_r |-> ladder_tap == sel_r[3:0] && ladder_cfg == sel_r[5:4]; endproperty
  a_sel: assert property (p_sel) else $error("ladder selects differ");
  property p_ctl; !wr && !wr_d_r |-> cmp_enable == ctl_r[7] && plus_sel == ctl_r[0]
    && port_a_pin_zero_oe == (ctl_r[7] & sel_r[7]); endproperty
  a_ctl: assert property (p_ctl) else $error("control outputs differ");
  property p_pin; !cmp_enable [*3] |-> !port_a_pin_zero_o; endproperty
  a_pin: assert property (p_pin) else $error("pin driven high while disabled");
endmodule
bind cmpio_top cmpio_props #(.AW(AW)) u_props (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .plus_sel(plus_sel), .ladder_cfg(ladder_cfg), .ladder_tap(ladder_tap),
  .cmp_enable(cmp_enable), .port_a_pin_zero_o(port_a_pin_zero_o), .port_a_pin_zero_oe(port_a_pin_zero_oe));

// ===== tb/cmpio_top_tb.sv
// self-checking bench for cmpio_top with the analog model
// assumes result settles within four cycles of a select change
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
module cmpio_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, tick = 0, err;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, q;
  wire [31:0] prdata;
  wire pready, pslverr, cmp_out, pen, ps, oe, pin, irq;
  wire [2:0] ms;
  wire [1:0] cfg;
  wire [3:0] tap;
  int num_errors = 0, total_checks = 0, n;
  cmpio_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer2_prescaled_clock(tick), .cmp_out(cmp_out), .minus_sel(ms), .plus_sel(ps), .ladder_cfg(cfg),
    .ladder_tap(tap), .cmp_enable(pen), .port_a_pin_zero_o(pin), .port_a_pin_zero_oe(oe), .irq(irq));
  cmpio_analog_model u_ana (.minus_sel(ms), .plus_sel(ps), .ladder_cfg(cfg), .ladder_tap(tap),
    .vdd_mv(32'd3200), .pin_mv(32'd1500), .cmp_out(cmp_out));
  task xfer(input w, input [11:0] a, input [31:0] d);
    @(posedge clk_sys);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
    // outputs launched by the edge after the write are looked at once settled
    @(negedge clk_sys);
  endtask
  task rd(input string nm, input [11:0] a, input [31:0] e);
    xfer(0, a, 0);
    `CHK(nm, e, q)
  endtask
  task settle;
    repeat (4) @(posedge clk_sys);
  endtask
  task close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #4 clk_sys = ~clk_sys;
  initial begin
    #200000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    rd("ctl", 0, 0);
    xfer(1, 4, 32'hff);
    rd("sel", 4, 32'hbf);
    xfer(1, 12'h20, 1);
    `CHK("slverr", 1'b1, err)
    xfer(1, 12'hc, 1);
    xfer(1, 0, 32'h85);
    for (n = 0; n < 16; n++) begin
      xfer(1, 4, n);
      settle;
      rd("sweep", 0, 32'h85 | (100 * (n + 9) > 1200 ? 32'h40 : 0));
    end
    `CHK("irq", 1'b1, irq)
    // the result rose on enable and fell at tap zero: both edge bits are set
    rd("stat", 8, 3);
    xfer(1, 12'hc, 0);
    `CHK("irq_mask", 1'b0, irq)
    xfer(1, 8, 3);
    rd("stat_clr", 8, 0);
    for (n = 6; n < 8; n++) begin
      xfer(1, 4, 32'h20 | n);
      settle;
      rd("span", 0, 32'h85 | (n == 7 ? 32'h40 : 0));
    end
    for (n = 0; n < 6; n++) begin
      xfer(1, 0, 32'h81 | (n << 1));
      settle;
      rd("minus", 0, 32'h81 | (n << 1) | (n == 2 ? 32'h40 : 0));
    end
    // plus input from pin four against the bandgap
    xfer(1, 0, 32'h84);
    settle;
    rd("plus_pin", 0, 32'hc4);
    xfer(1, 0, 32'h95);
    xfer(1, 4, 32'ha7);
    settle;
    rd("inv", 0, 32'h95);
    rd("raw", 12'h10, 1);
    `CHK("pin_oe", 1'b1, oe)
    `CHK("pin", 1'b0, pin)
    xfer(1, 0, 32'hb5);
    settle;
    rd("held", 0, 32'hf5);
    `CHK("pin_hi", 1'b1, pin)
    @(posedge clk_sys);
    tick <= 1;
    @(posedge clk_sys);
    tick <= 0;
    settle;
    rd("sampled", 0, 32'hb5);
    xfer(1, 0, 0);
    settle;
    rd("off", 0, 0);
    `CHK("off_oe", 1'b0, oe)
    close_out;
  end
endmodule
